// >>> design/smbts_consts.svh
// constants for the bus timing supervision block
// assumes a 200 MHz system clock; included by the package and the top
`ifndef SMBTS_CONSTS_SVH
`define SMBTS_CONSTS_SVH
`define SMBTS_CLK_MHZ 200
`define SMBTS_F_MAS_HZ 51200
`define SMBTS_T_BUF_NS 4700
`define SMBTS_T_LOW_NS 4700
`define SMBTS_T_HIGH_MAX_US 50
`define SMBTS_T_TIMEOUT_MS 30
`define SMBTS_T_SEXT_MS 25
`define SMBTS_T_MEXT_MS 10
`define SMBTS_CHG_ADDR 8'h12
`define SMBTS_CMD_CURR 8'h14
`define SMBTS_CMD_VOLT 8'h15
`define SMBTS_FIFO_DEPTH 32
`define SMBTS_CNT_W 24
`endif

// >>> design/smbts_pkg.sv
// types shared by the bus timing supervision block
// assumes smbts_consts.svh is on the include path
`include "smbts_consts.svh"
package smbts_pkg;
  // one charger broadcast: kind and 16-bit value
  typedef struct packed {
    logic volt;
    logic [15:0] value;
  } smbts_req_t;
  // status seen by the user side
  typedef struct packed {
    logic busy;
    logic master;
    logic bus_off;
    logic abort;
    logic timeout;
    logic nack;
    logic done;
  } smbts_stat_t;
  // master engine states, one-hot
  typedef enum logic [7:0] {
    MS_IDLE = 8'h01,
    MS_FREE = 8'h02,
    MS_START = 8'h04,
    MS_LOW = 8'h08,
    MS_HIGH = 8'h10,
    MS_STOP_LO = 8'h20,
    MS_STOP_HI = 8'h40,
    MS_STOP_END = 8'h80
  } smbts_ms_t;
endpackage

// >>> design/smbts_top.sv
// bus timing supervision and charger broadcast master
// assumes open-drain pins resolved outside; link_clk_i free running
// Notes on behaviour
// (R1) host clocks slave bus at 10-100 kHz
// (R2) master clock runs at nominal 51.2 kHz
// (R3) bus idle 4.7 us before start
// (R4) clock high over 50 us aborts
// (R5) clock low over timeout aborts transfer
// (R6) slave stretch total per message 25 ms
// (R7) master stretch total per message 10 ms
// (R8) master makes the acknowledge clock pulse
// (R9) broadcast charging current and voltage to charger
// (R10) bus off on long low, quick recovery
// (R11) wait idle, release lines after stop
`include "smbts_consts.svh"

module smbts_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // honest flags from the fill count
  assign in_ready_o = cnt_r != (AW+1)'(D);
  assign out_valid_o = cnt_r != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rp_r];

  // storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module smbts_top
  import smbts_pkg::*;
#(
  parameter logic [`SMBTS_CNT_W-1:0] T_HIGH_MAX_CYC = `SMBTS_CNT_W'(`SMBTS_T_HIGH_MAX_US * `SMBTS_CLK_MHZ),
  parameter logic [`SMBTS_CNT_W-1:0] T_TIMEOUT_CYC = `SMBTS_CNT_W'(`SMBTS_T_TIMEOUT_MS * 1000 * `SMBTS_CLK_MHZ),
  parameter logic [`SMBTS_CNT_W-1:0] T_SEXT_CYC = `SMBTS_CNT_W'(`SMBTS_T_SEXT_MS * 1000 * `SMBTS_CLK_MHZ),
  parameter logic [`SMBTS_CNT_W-1:0] T_MEXT_CYC = `SMBTS_CNT_W'(`SMBTS_T_MEXT_MS * 1000 * `SMBTS_CLK_MHZ)
) (
  // system clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link-side sampling clock
  input wire logic link_clk_i,
  // open-drain bus pins
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe_o,
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe_o,
  // charger broadcast requests
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire smbts_req_t req_i,
  // configuration and status
  input wire logic [`SMBTS_CNT_W-1:0] bus_off_time_i,
  output smbts_stat_t stat_o
);
  localparam logic [11:0] HALF_CYC = 12'(`SMBTS_CLK_MHZ * 1000000 / (2 * `SMBTS_F_MAS_HZ));
  localparam logic [11:0] QTR_CYC = HALF_CYC >> 1;
  localparam logic [11:0] T_BUF_CYC = 12'((`SMBTS_T_BUF_NS * `SMBTS_CLK_MHZ + 999) / 1000);
  localparam logic [`SMBTS_CNT_W-1:0] T_LOW_CYC = `SMBTS_CNT_W'((`SMBTS_T_LOW_NS * `SMBTS_CLK_MHZ + 999) / 1000);

  // saturating count, shared by every 24-bit timer
  function automatic logic [`SMBTS_CNT_W-1:0] sat_inc(input logic [`SMBTS_CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : v + `SMBTS_CNT_W'(1);
  endfunction

  // link domain: reset sync, pin sync, start and stop detection
  logic [1:0] lrst_r;
  logic [1:0] l_scl_r;
  logic [1:0] l_sda_r;
  logic l_sda_d_r;
  logic st_tgl_r;
  logic sp_tgl_r;

  always_ff @(posedge link_clk_i) begin
    lrst_r <= {lrst_r[0], rst_n_i};
  end

  // (R1) edges sampled far above 100 kHz
  always_ff @(posedge link_clk_i) begin
    l_scl_r <= {l_scl_r[0], bus_clock_pin_i};
    l_sda_r <= {l_sda_r[0], bus_data_pin_i};
    l_sda_d_r <= l_sda_r[1];
  end

  // events cross as toggles, so none is lost
  always_ff @(posedge link_clk_i) begin
    if (!lrst_r[1]) begin
      st_tgl_r <= 1'b0;
      sp_tgl_r <= 1'b0;
    end else begin
      if (l_scl_r[1] && l_sda_d_r && !l_sda_r[1]) st_tgl_r <= !st_tgl_r;
      if (l_scl_r[1] && !l_sda_d_r && l_sda_r[1]) sp_tgl_r <= !sp_tgl_r;
    end
  end

  // system domain: toggle and pin level synchronisers
  logic [2:0] st_s_r;
  logic [2:0] sp_s_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic start_p;
  logic stop_p;
  logic scl;
  logic sda;

  always_ff @(posedge ref_clk_i) begin
    st_s_r <= {st_s_r[1:0], st_tgl_r};
    sp_s_r <= {sp_s_r[1:0], sp_tgl_r};
    scl_s_r <= {scl_s_r[0], bus_clock_pin_i};
    sda_s_r <= {sda_s_r[0], bus_data_pin_i};
  end

  assign start_p = st_s_r[2] ^ st_s_r[1];
  assign stop_p = sp_s_r[2] ^ sp_s_r[1];
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];

  // request buffer; ready reaches the source
  smbts_req_t q_data;
  logic q_valid;
  logic q_pop;

  smbts_fifo #(.W($bits(smbts_req_t)), .D(`SMBTS_FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i(req_i),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop),
    .out_data_o(q_data)
  );

  // supervision state
  smbts_ms_t ms_r;
  logic busy_r;
  logic bus_off_r;
  logic scl_lo_r;
  logic sda_lo_r;
  logic [3:0] bit_r;
  logic [`SMBTS_CNT_W-1:0] low_cnt_r;
  logic [`SMBTS_CNT_W-1:0] high_cnt_r;
  logic [`SMBTS_CNT_W-1:0] off_cnt_r;
  logic [`SMBTS_CNT_W-1:0] sext_r;
  logic [`SMBTS_CNT_W-1:0] mext_r;
  logic tmo_c;
  logic hmax_c;
  logic sext_c;
  logic mext_c;
  logic arb_c;
  logic abort_c;

  // (R5) any clock low past timeout
  assign tmo_c = !scl && low_cnt_r == T_TIMEOUT_CYC;
  // (R4) overlong high within a message
  assign hmax_c = busy_r && scl && high_cnt_r == T_HIGH_MAX_CYC;
  // (R6) slave stretch budget spent
  assign sext_c = busy_r && sext_r == T_SEXT_CYC;
  // (R7) master stretch budget spent
  assign mext_c = busy_r && mext_r == T_MEXT_CYC;
  // lost arbitration: data low while released
  assign arb_c = ms_r == MS_HIGH && scl && !sda_lo_r && !sda && bit_r != 4'd8;
  assign abort_c = tmo_c || hmax_c || sext_c || mext_c || arb_c;

  // message in progress, from start to stop or abort
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
    end else if (abort_c || stop_p) begin
      busy_r <= 1'b0;
    end else if (start_p) begin
      busy_r <= 1'b1;
    end
  end

  // clock low and high interval timers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
    end else begin
      low_cnt_r <= scl ? '0 : sat_inc(low_cnt_r);
      high_cnt_r <= (scl && busy_r) ? sat_inc(high_cnt_r) : '0;
    end
  end

  // cumulative stretch per message, cleared at each start
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || start_p) begin
      sext_r <= '0;
      mext_r <= '0;
    end else if (busy_r && !scl) begin
      // (R6) slave holds our released clock low
      if (ms_r == MS_HIGH) sext_r <= sat_inc(sext_r);
      // (R7) far master's low beyond minimum low
      if (ms_r == MS_IDLE && low_cnt_r >= T_LOW_CYC) mext_r <= sat_inc(mext_r);
    end
  end

  // (R10) both lines low too long means bus off
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      off_cnt_r <= '0;
      bus_off_r <= 1'b0;
    end else if (scl || sda) begin
      off_cnt_r <= '0;
      bus_off_r <= 1'b0; // usable again on the next cycle
    end else begin
      off_cnt_r <= sat_inc(off_cnt_r);
      if (off_cnt_r == bus_off_time_i) bus_off_r <= 1'b1;
    end
  end

  // master engine registers
  logic [11:0] ph_r;
  logic [11:0] free_r;
  logic [1:0] byte_r;
  logic [31:0] shf_r;
  logic nack_r;
  logic done_r;

  // (R11) take a request only on an idle bus
  assign q_pop = ms_r == MS_IDLE && q_valid && !busy_r && !bus_off_r;

  // master sequence; abort always drops both lines
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || (abort_c && ms_r != MS_IDLE)) begin
      ms_r <= MS_IDLE;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
      ph_r <= '0;
      free_r <= '0;
      bit_r <= '0;
      byte_r <= '0;
      shf_r <= '0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      nack_r <= 1'b0;
      done_r <= 1'b0;
      unique case (ms_r)
        MS_IDLE: begin
          if (q_pop) begin
            // (R9) charger address, command, value low then high
            shf_r <= {`SMBTS_CHG_ADDR, q_data.volt ? `SMBTS_CMD_VOLT : `SMBTS_CMD_CURR,
                      q_data.value[7:0], q_data.value[15:8]};
            byte_r <= '0;
            free_r <= '0;
            ms_r <= MS_FREE;
          end
        end
        MS_FREE: begin
          // (R3) lines high and quiet for bus free time
          if (!scl || !sda || busy_r) begin
            free_r <= '0;
          end else if (free_r == T_BUF_CYC) begin
            sda_lo_r <= 1'b1;
            ph_r <= '0;
            ms_r <= MS_START;
          end else begin
            free_r <= free_r + 12'd1;
          end
        end
        MS_START: begin
          ph_r <= ph_r + 12'd1;
          if (ph_r == HALF_CYC) begin
            scl_lo_r <= 1'b1;
            ph_r <= '0;
            bit_r <= '0;
            ms_r <= MS_LOW;
          end
        end
        MS_LOW: begin
          // (R2) half period low at the nominal rate
          ph_r <= ph_r + 12'd1;
          if (ph_r == QTR_CYC) sda_lo_r <= bit_r != 4'd8 && !shf_r[31];
          if (ph_r == HALF_CYC) begin
            scl_lo_r <= 1'b0;
            ph_r <= '0;
            ms_r <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          // stretched clock freezes the phase count
          if (scl) ph_r <= ph_r + 12'd1;
          if (scl && ph_r == HALF_CYC) begin
            ph_r <= '0;
            scl_lo_r <= 1'b1;
            if (bit_r == 4'd8) begin
              // (R8) we clocked the acknowledge, sample it here
              bit_r <= '0;
              byte_r <= byte_r + 2'd1;
              nack_r <= sda;
              ms_r <= (sda || byte_r == 2'd3) ? MS_STOP_LO : MS_LOW;
            end else begin
              bit_r <= bit_r + 4'd1;
              shf_r <= {shf_r[30:0], 1'b0};
              ms_r <= MS_LOW;
            end
          end
        end
        MS_STOP_LO: begin
          ph_r <= ph_r + 12'd1;
          if (ph_r == QTR_CYC) sda_lo_r <= 1'b1;
          if (ph_r == HALF_CYC) begin
            scl_lo_r <= 1'b0;
            ph_r <= '0;
            ms_r <= MS_STOP_HI;
          end
        end
        MS_STOP_HI: begin
          if (scl) ph_r <= ph_r + 12'd1;
          if (scl && ph_r == HALF_CYC) begin
            sda_lo_r <= 1'b0;
            ph_r <= '0;
            ms_r <= MS_STOP_END;
          end
        end
        MS_STOP_END: begin
          // (R11) both lines released, hold off before next
          ph_r <= ph_r + 12'd1;
          if (ph_r == HALF_CYC) begin
            done_r <= 1'b1;
            ms_r <= MS_IDLE;
          end
        end
        default: begin
          ms_r <= MS_IDLE;
          scl_lo_r <= 1'b0;
          sda_lo_r <= 1'b0;
        end
      endcase
    end
  end

  // registered event pulses
  logic abort_r;
  logic tmo_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      abort_r <= 1'b0;
      tmo_r <= 1'b0;
    end else begin
      abort_r <= abort_c;
      tmo_r <= tmo_c;
    end
  end

  // open drain: only ever pull low
  assign bus_clock_pin_o = 1'b0;
  assign bus_clock_pin_oe_o = scl_lo_r;
  assign bus_data_pin_o = 1'b0;
  assign bus_data_pin_oe_o = sda_lo_r;

  // status bundle
  assign stat_o.busy = busy_r;
  assign stat_o.master = ms_r != MS_IDLE;
  assign stat_o.bus_off = bus_off_r;
  assign stat_o.abort = abort_r;
  assign stat_o.timeout = tmo_r;
  assign stat_o.nack = nack_r;
  assign stat_o.done = done_r;
endmodule

// >>> verification/smbts_chk_assertions.sv
// assertions on the ports of the bus timing supervision top
// assumes one system clock domain; bound to every top instance
`include "smbts_consts.svh"
module smbts_chk
  import smbts_pkg::*;
#(
  parameter logic [`SMBTS_CNT_W-1:0] T_TIMEOUT_CYC = 24'h5B8D80
) (
  // clock, reset and pins
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_clock_pin_i,
  input wire logic bus_clock_pin_o,
  input wire logic bus_clock_pin_oe_o,
  input wire logic bus_data_pin_i,
  input wire logic bus_data_pin_o,
  input wire logic bus_data_pin_oe_o,
  // configuration and status
  input wire logic [`SMBTS_CNT_W-1:0] bus_off_time_i,
  input wire smbts_stat_t stat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] lo_r, hi_r, off_r;
  logic [11:0] oe_r;
  // raw run lengths; pins lead the design's view by two flops
  always_ff @(posedge ref_clk_i) lo_r <= (!rst_n_i || bus_clock_pin_i) ? 24'h0 : lo_r + 24'h1;
  always_ff @(posedge ref_clk_i) hi_r <= (!rst_n_i || !(bus_clock_pin_i && bus_data_pin_i)) ? 24'h0 : hi_r + 24'h1;
  always_ff @(posedge ref_clk_i) off_r <= (!rst_n_i || bus_clock_pin_i || bus_data_pin_i) ? 24'h0 : off_r + 24'h1;
  // length of our own clock pull
  always_ff @(posedge ref_clk_i) oe_r <= (!rst_n_i || !bus_clock_pin_oe_o) ? 12'h0 : oe_r + 12'h1;
  // cycles since a refused byte while still master; bounds the stop
  logic [13:0] nk_r;
  always_ff @(posedge ref_clk_i) nk_r <= (!rst_n_i || !stat_o.master) ? 14'h0 :
    ((stat_o.nack || nk_r != 14'h0) ? nk_r + 14'h1 : nk_r);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_od_low: assert property (!bus_clock_pin_o && !bus_data_pin_o)
    else $error("open-drain output driven high");
  chk_abort_pulse: assert property (stat_o.abort |=> !stat_o.abort)
    else $error("abort wider than one cycle");
  chk_abort_lines_free: assert property ($rose(stat_o.abort) |-> !bus_clock_pin_oe_o && !bus_data_pin_oe_o)
    else $error("lines still pulled at abort");
  chk_timeout_window: assert property (stat_o.timeout |-> lo_r >= T_TIMEOUT_CYC && lo_r <= T_TIMEOUT_CYC + 24'h6)
    else $error("timeout at wrong low length");
  chk_timeout_aborts: assert property (stat_o.timeout |-> stat_o.abort)
    else $error("timeout without abort");
  chk_half_period: assert property ($fell(bus_clock_pin_oe_o) && oe_r != 12'h7A2 |-> stat_o.abort)
    else $error("clock low phase not 1954 cycles");
  chk_bus_free: assert property ($rose(bus_data_pin_oe_o) && !bus_clock_pin_oe_o |-> hi_r >= 24'h3AC)
    else $error("start without bus free time");
  chk_idle_release: assert property (!stat_o.master |-> !bus_clock_pin_oe_o && !bus_data_pin_oe_o)
    else $error("line pulled while not master");
  chk_nack_stop: assert property (nk_r <= 14'h1F40)
    else $error("no stop after refused byte");
  chk_busoff_set: assert property ($rose(stat_o.bus_off) |-> off_r >= bus_off_time_i)
    else $error("bus off too early");
  chk_busoff_clear: assert property (stat_o.bus_off && bus_clock_pin_i |-> ##[1:4] !stat_o.bus_off)
    else $error("bus off not left");
  cover property (stat_o.nack);
  cover property ($rose(stat_o.bus_off));
  cover property (stat_o.timeout);
endmodule

bind smbts_top smbts_chk #(.T_TIMEOUT_CYC(T_TIMEOUT_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_clock_pin_i(bus_clock_pin_i),
  .bus_clock_pin_o(bus_clock_pin_o), .bus_clock_pin_oe_o(bus_clock_pin_oe_o),
  .bus_data_pin_i(bus_data_pin_i), .bus_data_pin_o(bus_data_pin_o),
  .bus_data_pin_oe_o(bus_data_pin_oe_o), .bus_off_time_i(bus_off_time_i), .stat_o(stat_o));

// >>> verification/smbts_chg_model.sv
// charger model on the far side of the bus: acks bytes, may stretch
// assumes resolved open-drain lines with pull-ups, sampled on the system clock
module smbts_chg_model (
  // sampling clock and bus levels
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // bytes to acknowledge, stretch length
  input wire logic [2:0] ack_n_i,
  input wire logic [15:0] str_i,
  // pulls and last byte seen
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q = 1'b1, sda_q = 1'b1;
  logic [7:0] sh = 8'h0;
  int bit_n = 0, byte_n = 0, st = 0, sc = 0;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    byte_o = 8'h0;
  end
  // start resets framing; rising clock shifts bits in
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      bit_n <= 0;
      byte_n <= 0;
      st <= str_i;
    end else if (!scl_q && scl_i) begin
      sh <= {sh[6:0], sda_i};
      if (bit_n == 7) byte_o <= {sh[6:0], sda_i};
      bit_n <= (bit_n == 8) ? 0 : bit_n + 1;
      if (bit_n == 8) byte_n <= byte_n + 1;
    end
    if (scl_q && !scl_i) sda_oe_o <= (bit_n == 8) && (byte_n < ack_n_i);
    if (scl_q && !scl_i && st > 0) begin
      scl_oe_o <= 1'b1;
      sc <= st;
      st <= 0;
    end else if (sc > 1) sc <= sc - 1;
    else if (sc == 1) begin
      sc <= 0;
      scl_oe_o <= 1'b0;
    end
  end
endmodule

// >>> verification/smbts_tb.sv
// self-checking bench for the bus timing supervision top
// assumes the charger model and the bound checker are compiled alongside
module testbench
  import smbts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HM = 4000;
  localparam int TO = 6000;
  logic ref_clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0;
  logic req_ready_o, scl_oe, sda_oe, m_scl, m_sda, tb_scl = 1'b0, tb_sda = 1'b0;
  smbts_req_t req_i = 17'h0;
  smbts_stat_t stat_o;
  logic [23:0] off_t = 24'h40;
  logic [2:0] ack_n = 3'h0;
  logic [15:0] str = 16'h0;
  logic [7:0] m_byte;
  logic rdy = 1'b1;
  int failures = 0, checked = 0, seed = 50178, n, acc;
  // open-drain wires with pull-ups
  wire logic scl = !(scl_oe || m_scl || tb_scl);
  wire logic sda = !(sda_oe || m_sda || tb_sda);
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  // link clock, phase unrelated
  initial begin
    #17;
    forever #62.5 link_clk_i = ~link_clk_i;
  end
  smbts_top #(.T_HIGH_MAX_CYC(24'(HM)), .T_TIMEOUT_CYC(24'(TO)), .T_SEXT_CYC(24'h7D0), .T_MEXT_CYC(24'h3E8)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .bus_clock_pin_i(scl), .bus_clock_pin_o(), .bus_clock_pin_oe_o(scl_oe),
    .bus_data_pin_i(sda), .bus_data_pin_o(), .bus_data_pin_oe_o(sda_oe),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .bus_off_time_i(off_t), .stat_o(stat_o));
  smbts_chg_model chg (.clk_i(ref_clk_i), .scl_i(scl), .sda_i(sda), .ack_n_i(ack_n), .str_i(str),
    .scl_oe_o(m_scl), .sda_oe_o(m_sda), .byte_o(m_byte));
  // an event seen n cycles after its cause lies in the window around t
  function automatic bit in_win(int n, int t);
    return n >= t - 2 && n <= t + 6;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // waits on falling edges for a status bit, then compares it
  task automatic expect_st(string nm, int b, logic v, int lim, output int k);
    for (k = 0; k < lim; k++) begin
      @(negedge ref_clk_i);
      if (stat_o[b] === v) break;
    end
    cmp(nm, 32'(v), 32'(stat_o[b]));
  endtask
  task automatic send(logic v);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_i <= {v, 16'($random(seed))};
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
  endtask
  // bench pulls on clock and data, then waits
  task automatic hold(logic c, logic d, int k);
    @(posedge ref_clk_i);
    tb_scl <= c;
    tb_sda <= d;
    repeat (k) @(posedge ref_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // link domain reset lags, so hold across four link edges
    repeat (4) @(posedge link_clk_i);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    cmp("stat_rst", 32'h0, 32'(stat_o));
    cmp("ready_rst", 32'h1, 32'(req_ready_o));
    cmp("oe_rst", 32'h0, 32'({scl_oe, sda_oe}));
    // address refused by the charger
    send(1'($random(seed)));
    expect_st("nack", 1, 1'b1, 60000, n);
    cmp("addr_byte", 32'h12, 32'(m_byte));
    expect_st("master_end", 5, 1'b0, 8000, n);
    cmp("done_end", 32'h1, 32'(stat_o.done));
    cmp("oe_end", 32'h0, 32'({scl_oe, sda_oe}));
    // slave stretches the first low past its budget
    ack_n = 3'h4;
    str = 16'h1194;
    send(1'b0);
    expect_st("sext_abort", 3, 1'b1, 20000, n);
    cmp("sext_to", 32'h0, 32'(stat_o.timeout));
    str = 16'h0;
    ack_n = 3'h0;
    hold(0, 0, 3000);
    // clock alone held low
    hold(1, 0, 0);
    expect_st("timeout", 2, 1'b1, TO + 20, n);
    cmp("timeout_at", 32'h1, 32'(in_win(n, TO)));
    cmp("no_off", 32'h0, 32'(stat_o.bus_off));
    hold(0, 0, 1000);
    // far master: start, one low, then a stuck high clock
    hold(0, 1, 300);
    expect_st("busy", 6, 1'b1, 400, n);
    hold(1, 1, 1000);
    hold(0, 1, 0);
    expect_st("high_abort", 3, 1'b1, HM + 20, n);
    cmp("high_at", 32'h1, 32'(in_win(n, HM)));
    // stop, then idle before the next start
    hold(0, 0, 1000);
    hold(0, 1, 300);
    // far master clock at 100 kHz
    repeat (3) begin
      hold(1, 1, 1000);
      hold(0, 1, 1000);
    end
    hold(1, 1, 0);
    expect_st("mext_abort", 3, 1'b1, 3000, n);
    cmp("mext_at", 32'h1, 32'(n > 940 && n < 1940));
    hold(0, 1, 100);
    hold(0, 0, 1000);
    // both lines low: bus off holds the engine while the buffer fills
    off_t <= 24'(64 + ($random(seed) & 63));
    hold(1, 1, 0);
    expect_st("bus_off", 4, 1'b1, 300, n);
    cmp("off_at", 32'h1, 32'(n >= off_t));
    acc = 0;
    // a refused entry keeps its data until the buffer takes it
    repeat (40) begin
      @(posedge ref_clk_i);
      req_valid_i <= 1'b1;
      if (rdy) req_i <= 17'($random(seed));
      @(negedge ref_clk_i);
      rdy = req_ready_o;
      if (rdy) acc++;
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    @(negedge ref_clk_i);
    cmp("fifo_taken", 32'h20, 32'(acc));
    cmp("ready_full", 32'h0, 32'(req_ready_o));
    hold(0, 1, 0);
    expect_st("bus_on", 4, 1'b0, 200, n);
    hold(0, 0, 100);
    tally_and_finish;
  end
  // cut a hang short well past the expected run length
  initial begin
    // a clean run takes about 77k cycles
    repeat (95000) @(posedge ref_clk_i);
    failures++;
    tally_and_finish;
  end
endmodule
